// file: core/sfb_cfg.svh
// constants of the serial flash front end: status fields, frame lengths, times
// assumes a 250 MHz system clock; included by its bare name
`ifndef SFB_CFG_SVH
`define SFB_CFG_SVH

// ************************************************************
// clock and internal cycle times
// ************************************************************
`define SFB_CLK_PERIOD_NS 4
`define SFB_CYC_PER_US    (1000 / `SFB_CLK_PERIOD_NS)
`define SFB_T_W_US        15
`define SFB_T_PP_US       800
`define SFB_T_SSE_US      70000
`define SFB_T_SE_US       700000
`define SFB_T_BE_US       8000000

// ************************************************************
// status register layout
// ************************************************************
`define SFB_SR_WIP        0
`define SFB_SR_WEL        1
`define SFB_SR_GUARD_LO   2
`define SFB_SR_GUARD_HI   4
`define SFB_SR_CFG_LO     2
`define SFB_SR_CFG_HI     7
`define SFB_SR_RESET      8'h00

// ************************************************************
// frame lengths in clock pulses
// ************************************************************
`define SFB_CMD_BITS      16'h0008
`define SFB_WRSR_BITS     16'h0010
`define SFB_HDR_BITS      16'h0020
`define SFB_PP_MIN_BITS   16'h0028
`define SFB_DP_MIN_BITS   16'h0024
`define SFB_BITCNT_MAX    16'hFFFF
`define SFB_PIN_RESET     6'h3C

`endif

// file: core/sfb_pkg.sv
// types shared by the serial flash front end
// assumes nothing beyond a SystemVerilog compiler
package sfb_pkg;

	typedef logic [7:0] sfb_byte_t;

	typedef enum logic [7:0] {
		OP_WREN  = 8'h06,
		OP_WRDI  = 8'h04,
		OP_RDSR  = 8'h05,
		OP_WRSR  = 8'h01,
		OP_PP    = 8'h02,
		OP_DP    = 8'hA2,
		OP_SSE   = 8'h20,
		OP_SE    = 8'hD8,
		OP_BE    = 8'hC7
	} sfb_op_e;

	typedef enum logic [1:0] {
		ER_SUB = 2'h0,
		ER_SEC = 2'h1,
		ER_ALL = 2'h2
	} sfb_erase_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SCAN = 3'h1,
		ST_RDW  = 3'h2,
		ST_MRG  = 3'h3,
		ST_WAIT = 3'h4
	} sfb_state_e;

endpackage

// file: core/sfb_pb_if.sv
// page buffer link between the command core and its byte store
// assumes both ends run on the system clock
interface sfb_pb_if;
	logic       clr;
	logic       wr_en;
	logic [7:0] wr_idx;
	logic [7:0] wr_data;
	logic [7:0] rd_idx;
	logic [7:0] rd_data;
	logic       rd_valid;

	modport core  (output clr, output wr_en, output wr_idx, output wr_data,
		output rd_idx, input rd_data, input rd_valid);
	modport store (input clr, input wr_en, input wr_idx, input wr_data,
		input rd_idx, output rd_data, output rd_valid);
endinterface

// file: core/sfb_sync.sv
// two-stage synchroniser for the serial pins
// assumes the pins are asynchronous to clk; no reset value, RST_VAL and rst are unused
module sfb_sync #(
	parameter logic [5:0] RST_VAL = 6'h00
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [5:0] d,
	output logic      [5:0] q
);
	logic [5:0] meta_r;

	// first stage feeds only the second stage; pins keep flowing through reset,
	// so a forced reset level cannot fake a select or clock edge at release
	always_ff @(posedge clk) begin
		meta_r <= d;
		q      <= meta_r;
	end
endmodule

// file: core/sfb_pagebuf.sv
// 256-byte page buffer with one valid flag per byte
// assumes clr and wr_en are never high in the same cycle
module sfb_pagebuf (
	input wire logic clk,
	input wire logic rst,
	sfb_pb_if.store  pb
);
	logic [7:0]   mem_r [256];
	logic [255:0] valid_r;

	// later bytes at the same index overwrite earlier ones: data wraps in the page
	always_ff @(posedge clk) begin
		if (pb.wr_en) begin
			mem_r[pb.wr_idx] <= pb.wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || pb.clr) begin
			valid_r <= '0;
		end else if (pb.wr_en) begin
			valid_r[pb.wr_idx] <= 1'b1;
		end
	end

	assign pb.rd_data  = mem_r[pb.rd_idx];
	assign pb.rd_valid = valid_r[pb.rd_idx];
endmodule

// file: core/sfb_flash_core.sv
// serial flash front end: pin sampling, command decode, write operations
// assumes the serial clock is far slower than CLK_SYS and a byte-wide array
// port that answers a read strobe with data in the following cycle
//
// The register addresses and the plain strobed port were left to the implementer.
`include "sfb_cfg.svh"

// Contract
// - sample command, address and data from the primary line on clock rise.
// - change the output line only after a serial clock fall.
// - select high means deselected and output line floating.
// - deselect gives standby; running internal cycles continue; select low activates.
// - no command before the first select fall after power-up.
// - pause floats the output and ignores clock and input line.
// - pause starts only while selected.
// - write-protect low freezes the area guard bits.
// - both clock-idle-low and clock-idle-high modes work with same edges.
// - page write programs up to 256 bytes in one page, ones to zeros.
// - dual program takes up to 256 bytes on two lines, ones to zeros.
// - subsector, sector and full erase leave region at FFh.
// - erase needs a preceding write enable.
// - in-progress flag set during internal cycles, cleared at end.
// - dual program samples the output line as second input on rise.
// - data-modifying commands need the modify-permit latch set.
// - modifying commands rejected unless clock pulses are whole bytes.
module sfb_flash_core #(
	parameter int unsigned PP_CYC  = `SFB_T_PP_US * `SFB_CYC_PER_US,
	parameter int unsigned SSE_CYC = `SFB_T_SSE_US * `SFB_CYC_PER_US,
	parameter int unsigned SE_CYC  = `SFB_T_SE_US * `SFB_CYC_PER_US,
	parameter int unsigned BE_CYC  = `SFB_T_BE_US * `SFB_CYC_PER_US
) (
	input  wire logic         CLK_SYS,
	input  wire logic         RST,
	input  wire logic         SCK,
	input  wire logic         CS_N,
	input  wire logic         HOLD_N,
	input  wire logic         WP_N,
	input  wire logic         DQ0_I,
	output logic              DQ0_O,
	output logic              DQ0_OE,
	input  wire logic         DQ1_I,
	output logic              DQ1_O,
	output logic              DQ1_OE,
	output logic              ACTIVE_PWR,
	output logic              MEM_RD_STB,
	output logic              MEM_WR_STB,
	output logic              MEM_ERASE_STB,
	output sfb_pkg::sfb_erase_e MEM_ERASE_KIND,
	output logic [19:0]       MEM_ADDR,
	output logic [7:0]        MEM_WDATA,
	input  wire logic [7:0]   MEM_RDATA
);
	import sfb_pkg::*;

	localparam int unsigned W_CYC = `SFB_T_W_US * `SFB_CYC_PER_US;

	// ************************************************************
	// pin sampling
	// ************************************************************
	logic [5:0] pins_s;
	sfb_sync #(.RST_VAL(`SFB_PIN_RESET)) u_sync (
		.clk (CLK_SYS),
		.rst (RST),
		.d   ({HOLD_N, WP_N, CS_N, SCK, DQ1_I, DQ0_I}),
		.q   (pins_s)
	);

	sfb_pb_if pb ();
	sfb_pagebuf u_pagebuf (
		.clk (CLK_SYS),
		.rst (RST),
		.pb  (pb)
	);

	function automatic logic [7:0] data_index(input logic [15:0] cnt, input logic dual);
		logic [15:0] d;
		d = cnt - `SFB_HDR_BITS;
		return dual ? d[9:2] : d[10:3];
	endfunction

	wire dq0_s    = pins_s[0];
	wire dq1_s    = pins_s[1];
	wire sck_s    = pins_s[2];
	wire cs_n_s   = pins_s[3];
	wire wp_n_s   = pins_s[4];
	wire hold_n_s = pins_s[5];

	logic        sck_d_r;
	logic        cs_n_d_r;
	logic        armed_r;
	logic        hold_r;
	logic        shown_r;
	logic [15:0] bitcnt_r;
	logic [7:0]  shift_r;
	logic [7:0]  cmd_r;
	logic [23:0] addr_r;
	logic [7:0]  sr_r;
	sfb_state_e  state_r;
	logic [7:0]  idx_r;
	logic [11:0] page_r;
	logic [31:0] cnt_r;

	// ************************************************************
	// frame decode
	// ************************************************************
	wire sel      = !cs_n_s;
	wire cs_fall  = cs_n_d_r && !cs_n_s;
	wire cs_rise  = !cs_n_d_r && cs_n_s;
	wire hold_now = sel && !hold_n_s;
	wire float_o  = !sel || hold_now;
	wire live     = sel && armed_r && !hold_r;
	// edges are found on the sampled clock, so the idle level does not matter
	wire sck_rise = live && sck_s && !sck_d_r;
	wire sck_fall = live && !sck_s && sck_d_r;
	wire internal_cycle_active      = sr_r[`SFB_SR_WIP];
	wire modify_permit_latch      = sr_r[`SFB_SR_WEL];
	wire write_ok = modify_permit_latch && !internal_cycle_active;
	wire [2:0] guard = sr_r[`SFB_SR_GUARD_HI:`SFB_SR_GUARD_LO];
	wire dual     = (cmd_r == OP_DP) && (bitcnt_r >= `SFB_HDR_BITS);
	wire [7:0] byte_nxt = dual ? {shift_r[5:0], dq1_s, dq0_s}
		: {shift_r[6:0], dq0_s};
	wire byte_done = sck_rise && (dual ? (bitcnt_r[1:0] == 2'h3)
		: (bitcnt_r[2:0] == 3'h7));
	wire [12:0] byte_no = bitcnt_r[15:3];
	wire is_data  = (bitcnt_r >= `SFB_HDR_BITS)
		&& ((cmd_r == OP_PP) || (cmd_r == OP_DP));
	wire rdsr_out = (cmd_r == OP_RDSR) && (bitcnt_r >= `SFB_CMD_BITS);

	// ************************************************************
	// commit at end of frame
	// ************************************************************
	wire frame    = cs_rise && armed_r;
	wire whole8   = bitcnt_r[2:0] == 3'h0;
	wire c_wren   = frame && (cmd_r == OP_WREN) && (bitcnt_r == `SFB_CMD_BITS) && !internal_cycle_active;
	wire c_wrdi   = frame && (cmd_r == OP_WRDI) && (bitcnt_r == `SFB_CMD_BITS) && !internal_cycle_active;
	wire c_wrsr   = frame && (cmd_r == OP_WRSR) && (bitcnt_r == `SFB_WRSR_BITS) && write_ok;
	wire c_pp     = frame && (cmd_r == OP_PP) && (bitcnt_r >= `SFB_PP_MIN_BITS)
		&& whole8 && write_ok;
	wire c_dp     = frame && (cmd_r == OP_DP) && (bitcnt_r >= `SFB_DP_MIN_BITS)
		&& (bitcnt_r[1:0] == 2'h0) && write_ok;
	wire c_sse    = frame && (cmd_r == OP_SSE) && (bitcnt_r == `SFB_HDR_BITS) && write_ok;
	wire c_se     = frame && (cmd_r == OP_SE) && (bitcnt_r == `SFB_HDR_BITS) && write_ok;
	// full erase only while no area is guarded
	wire c_be     = frame && (cmd_r == OP_BE) && (bitcnt_r == `SFB_CMD_BITS)
		&& write_ok && (guard == 3'h0);
	wire c_prog   = c_pp || c_dp;
	wire c_erase  = c_sse || c_se || c_be;
	wire c_start  = c_wrsr || c_prog || c_erase;
	wire done     = (state_r == ST_WAIT) && (cnt_r == 32'h0000_0000);

	// ************************************************************
	// serial capture
	// ************************************************************
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			// track the pins in reset: no false edge after release
			sck_d_r  <= sck_s;
			cs_n_d_r <= cs_n_s;
			armed_r  <= 1'b0;
			hold_r   <= 1'b0;
		end else begin
			sck_d_r  <= sck_s;
			cs_n_d_r <= cs_n_s;
			hold_r   <= hold_now;
			if (cs_fall) begin
				armed_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			bitcnt_r <= 16'h0000;
			shift_r  <= 8'h00;
			cmd_r    <= 8'h00;
			addr_r   <= 24'h00_0000;
		end else begin
			if (cs_fall) begin
				bitcnt_r <= 16'h0000;
			end else if (sck_rise && (bitcnt_r != `SFB_BITCNT_MAX)) begin
				bitcnt_r <= bitcnt_r + 16'h0001;
			end
			if (sck_rise) begin
				shift_r <= byte_nxt;
			end
			if (byte_done && (byte_no == 13'h0000)) begin
				cmd_r <= byte_nxt;
			end else if (byte_done && !is_data && (byte_no < 13'h0004)) begin
				addr_r <= {addr_r[15:0], byte_nxt};
			end
		end
	end

	// page data lands at column + count, modulo the page
	assign pb.clr     = cs_fall && !internal_cycle_active;
	assign pb.wr_en   = byte_done && is_data && write_ok;
	assign pb.wr_idx  = addr_r[7:0] + data_index(bitcnt_r, dual);
	assign pb.wr_data = byte_nxt;
	assign pb.rd_idx  = idx_r;

	// ************************************************************
	// serial output
	// ************************************************************
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			shown_r <= 1'b0;
			DQ1_O   <= 1'b0;
			DQ1_OE  <= 1'b0;
			DQ0_O   <= 1'b0;
			DQ0_OE  <= 1'b0;
		end else begin
			if (cs_fall) begin
				shown_r <= 1'b0;
			end else if (sck_fall && rdsr_out) begin
				shown_r <= 1'b1;
				DQ1_O   <= sr_r[3'h7 - bitcnt_r[2:0]];
			end
			// status stays live, so repeated bytes show the flag as it falls
			DQ1_OE <= !float_o && (shown_r || (sck_fall && rdsr_out));
		end
	end

	// ************************************************************
	// status register
	// ************************************************************
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			sr_r <= `SFB_SR_RESET;
		end else begin
			if (c_wren) begin
				sr_r[`SFB_SR_WEL] <= 1'b1;
			end else if (c_wrdi || done) begin
				sr_r[`SFB_SR_WEL] <= 1'b0;
			end
			if (c_start) begin
				sr_r[`SFB_SR_WIP] <= 1'b1;
			end else if (done) begin
				sr_r[`SFB_SR_WIP] <= 1'b0;
			end
			if (c_wrsr && wp_n_s) begin
				sr_r[`SFB_SR_CFG_HI:`SFB_SR_CFG_LO] <=
					shift_r[`SFB_SR_CFG_HI:`SFB_SR_CFG_LO];
			end
		end
	end

	// ************************************************************
	// internal cycle sequencer
	// ************************************************************
	// runs on regardless of select, so deselect only drops to standby after it
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state_r        <= ST_IDLE;
			idx_r          <= 8'h00;
			page_r         <= 12'h000;
			cnt_r          <= 32'h0000_0000;
			MEM_RD_STB     <= 1'b0;
			MEM_WR_STB     <= 1'b0;
			MEM_ERASE_STB  <= 1'b0;
			MEM_ERASE_KIND <= ER_SUB;
			MEM_ADDR       <= 20'h0_0000;
			MEM_WDATA      <= 8'hFF;
			ACTIVE_PWR     <= 1'b0;
		end else begin
			MEM_RD_STB    <= 1'b0;
			MEM_WR_STB    <= 1'b0;
			MEM_ERASE_STB <= 1'b0;
			ACTIVE_PWR    <= sel || internal_cycle_active;
			case (state_r)
				ST_IDLE: begin
					if (c_prog) begin
						idx_r   <= 8'h00;
						page_r  <= addr_r[19:8];
						state_r <= ST_SCAN;
					end else if (c_erase) begin
						MEM_ERASE_STB  <= 1'b1;
						MEM_ERASE_KIND <= c_be ? ER_ALL : (c_se ? ER_SEC : ER_SUB);
						MEM_ADDR       <= addr_r[19:0];
						cnt_r   <= c_be ? BE_CYC : (c_se ? SE_CYC : SSE_CYC);
						state_r <= ST_WAIT;
					end else if (c_wrsr) begin
						cnt_r   <= W_CYC;
						state_r <= ST_WAIT;
					end
				end
				ST_SCAN: begin
					if (pb.rd_valid) begin
						MEM_RD_STB <= 1'b1;
						MEM_ADDR   <= {page_r, idx_r};
						state_r    <= ST_RDW;
					end else if (idx_r == 8'hFF) begin
						cnt_r   <= PP_CYC;
						state_r <= ST_WAIT;
					end else begin
						idx_r <= idx_r + 8'h01;
					end
				end
				ST_RDW: begin
					state_r <= ST_MRG;
				end
				ST_MRG: begin
					// and-merge: a program can only take ones to zeros
					MEM_WR_STB <= 1'b1;
					MEM_WDATA  <= MEM_RDATA & pb.rd_data;
					if (idx_r == 8'hFF) begin
						cnt_r   <= PP_CYC;
						state_r <= ST_WAIT;
					end else begin
						idx_r   <= idx_r + 8'h01;
						state_r <= ST_SCAN;
					end
				end
				ST_WAIT: begin
					if (cnt_r == 32'h0000_0000) begin
						state_r <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 32'h0000_0001;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// file: sim/sfb_core_sva.sv
// concurrent checks on the serial flash front end pins and array port
// assumes bind onto sfb_flash_core, everything sampled on CLK_SYS
module sfb_core_sva (
	input wire logic       CLK_SYS,
	input wire logic       RST,
	input wire logic       SCK,
	input wire logic       CS_N,
	input wire logic       HOLD_N,
	input wire logic       DQ0_OE,
	input wire logic       DQ1_O,
	input wire logic       DQ1_OE,
	input wire logic       ACTIVE_PWR,
	input wire logic       MEM_RD_STB,
	input wire logic       MEM_WR_STB,
	input wire logic       MEM_ERASE_STB,
	input wire logic [7:0] MEM_WDATA,
	input wire logic [7:0] MEM_RDATA
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	logic       armed_r;
	logic       rd_d_r;
	logic [7:0] old_r;
	// the raw pin falls before the synchronised one, so arming here is never late
	always_ff @(posedge CLK_SYS) begin
		if (RST)
			armed_r <= 1'b0;
		else if ($fell(CS_N))
			armed_r <= 1'b1;
		rd_d_r <= MEM_RD_STB;
		if (rd_d_r)
			old_r <= MEM_RDATA;
	end
	// ************************************************************
	// assertions
	// ************************************************************
	desel_float_a: assert property (CS_N [*6] |-> !DQ1_OE)
		else $error("output driven while deselected");
	pause_float_a: assert property (!HOLD_N [*6] |-> !DQ1_OE)
		else $error("output driven during pause");
	out_on_fall_a: assert property (DQ1_OE && $past(DQ1_OE) && !CS_N && !$past(CS_N, 4)
		&& $changed(DQ1_O) |-> !SCK && !$past(SCK))
		else $error("output changed away from a clock fall");
	select_pwr_a: assert property (!CS_N [*6] |-> ACTIVE_PWR)
		else $error("selected but not active");
	arm_first_a: assert property (!armed_r |-> !MEM_WR_STB && !MEM_ERASE_STB)
		else $error("array changed before first select fall");
	merge_order_a: assert property (MEM_WR_STB |-> $past(MEM_RD_STB, 2)
		|| $past(MEM_RD_STB, 3) || $past(MEM_RD_STB, 4))
		else $error("write without preceding read");
	one_to_zero_a: assert property (MEM_WR_STB |-> (MEM_WDATA & ~old_r) == 8'h00)
		else $error("write sets a cleared bit");
	dq0_input_a: assert property (!DQ0_OE)
		else $error("primary line driven");
	erase_once_a: assert property (MEM_ERASE_STB |=> !MEM_ERASE_STB [*8])
		else $error("erase strobe repeated");
endmodule

bind sfb_flash_core sfb_core_sva u_sva (.CLK_SYS(CLK_SYS), .RST(RST), .SCK(SCK), .CS_N(CS_N),
	.HOLD_N(HOLD_N), .DQ0_OE(DQ0_OE), .DQ1_O(DQ1_O), .DQ1_OE(DQ1_OE),
	.ACTIVE_PWR(ACTIVE_PWR), .MEM_RD_STB(MEM_RD_STB), .MEM_WR_STB(MEM_WR_STB),
	.MEM_ERASE_STB(MEM_ERASE_STB), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA));

// file: sim/sfb_arr_model.sv
// byte array behind the core's memory port, a 4 KB window of the space
// assumes one strobe a cycle; any erase kind clears the whole window
module sfb_arr_model (
	input wire logic        clk,
	input wire logic        rd_stb,
	input wire logic        wr_stb,
	input wire logic        er_stb,
	input wire logic [19:0] addr,
	input wire logic [7:0]  wdata,
	output logic     [7:0]  rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:4095];
	initial begin
		rdata = 8'h00;
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'hFF;
	end
	always @(posedge clk) begin
		if (er_stb)
			for (int i = 0; i < 4096; i++)
				mem[i] <= 8'hFF;
		if (wr_stb)
			mem[addr[11:0]] <= wdata;
		// data stand only in the cycle after the strobe, a moving pattern elsewhere
		rdata <= rd_stb ? mem[addr[11:0]] : ~rdata;
	end
endmodule

// file: sim/testbench.sv
// bit-banged serial host driving the flash front end and an array model
// assumes sfb_pkg, sfb_pb_if and the core sources are compiled first
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sfb_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, sck = 1'b0, cs_n = 1'b0, hold_n = 1'b1;
	logic        wp_n = 1'b1, d0 = 1'b0, d1 = 1'b0, cpol = 1'b0, b;
	logic        dq0_o, dq0_oe, dq1_o, dq1_oe, act, rd_stb, wr_stb, er_stb;
	sfb_erase_e  er_kind;
	logic [19:0] addr;
	logic [7:0]  wdata, rdata, st, q;
	int          n_mismatch = 0;
	int          num_checks = 0;
	always #2 clk = ~clk;
	// long internal cycles so that a single status read lands inside one
	sfb_flash_core #(.PP_CYC(2000), .SSE_CYC(2000), .SE_CYC(2000), .BE_CYC(2000)) uut (
		.CLK_SYS(clk), .RST(rst), .SCK(sck), .CS_N(cs_n), .HOLD_N(hold_n), .WP_N(wp_n),
		.DQ0_I(d0), .DQ0_O(dq0_o), .DQ0_OE(dq0_oe), .DQ1_I(dq1_oe ? dq1_o : d1),
		.DQ1_O(dq1_o), .DQ1_OE(dq1_oe), .ACTIVE_PWR(act), .MEM_RD_STB(rd_stb),
		.MEM_WR_STB(wr_stb), .MEM_ERASE_STB(er_stb), .MEM_ERASE_KIND(er_kind),
		.MEM_ADDR(addr), .MEM_WDATA(wdata), .MEM_RDATA(rdata));
	sfb_arr_model u_arr (.clk(clk), .rd_stb(rd_stb), .wr_stb(wr_stb), .er_stb(er_stb),
		.addr(addr), .wdata(wdata), .rdata(rdata));
	// ************************************************************
	// host tasks
	// ************************************************************
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// the returned line value is taken just before the rising edge
	task automatic pulse(logic a, logic c, output logic o);
		@(posedge clk);
		sck <= 1'b0;
		d0  <= a;
		d1  <= c;
		tick(20);
		o = dq1_o;
		sck <= 1'b1;
		tick(20);
	endtask
	task automatic xfer(logic [7:0] v, int n, output logic [7:0] o);
		for (int i = n - 1; i >= 0; i--)
			pulse(v[i], 1'b0, o[i]);
	endtask
	task automatic sel();
		@(posedge clk);
		cs_n <= 1'b0;
		tick(10);
	endtask
	task automatic desel();
		@(posedge clk);
		sck <= cpol;
		tick(10);
		cs_n <= 1'b1;
		tick(20);
	endtask
	task automatic cmd(logic [7:0] op);
		sel();
		xfer(op, 8, q);
		desel();
	endtask
	task automatic wr2(logic [7:0] op, logic [7:0] v);
		sel();
		xfer(op, 8, q);
		xfer(v, 8, q);
		desel();
	endtask
	task automatic hdr(logic [7:0] op, logic [23:0] a);
		sel();
		xfer(op, 8, q);
		for (int i = 2; i >= 0; i--)
			xfer(a[8*i +: 8], 8, q);
	endtask
	task automatic rdsr();
		sel();
		xfer(OP_RDSR, 8, st);
		xfer(8'h00, 8, st);
		desel();
	endtask
	task automatic idle_wait();
		for (int k = 0; k < 100; k++) begin
			rdsr();
			if (st[0] === 1'b0)
				return;
		end
		check(st, 8'h00);
		tally_and_finish();
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		tick(20);
		rst <= 1'b0;
		tick(5);
		xfer(OP_WREN, 8, q);
		desel();
		rdsr();
		check(st, 8'h00);
		cmd(OP_WREN);
		rdsr();
		check(st, 8'h02);
		cmd(OP_WRDI);
		hdr(OP_PP, 24'h000010);
		xfer(8'h00, 8, q);
		desel();
		rdsr();
		check(st, 8'h00);
		check(u_arr.mem[12'h010], 8'hFF);
		cmd(OP_WREN);
		hdr(OP_PP, 24'h0000FE);
		for (int i = 1; i <= 3; i++)
			xfer(8'h11 * i[7:0], 8, q);
		desel();
		rdsr();
		check(st, 8'h03);
		idle_wait();
		check(st, 8'h00);
		check({7'h00, act}, 8'h00);
		check(u_arr.mem[12'h0FE], 8'h11);
		check(u_arr.mem[12'h0FF], 8'h22);
		check(u_arr.mem[12'h000], 8'h33);
		cmd(OP_WREN);
		hdr(OP_PP, 24'h0000FE);
		xfer(8'hF0, 8, q);
		xfer(8'h00, 1, q);
		desel();
		rdsr();
		check(st, 8'h02);
		check(u_arr.mem[12'h0FE], 8'h11);
		hdr(OP_PP, 24'h0000FE);
		xfer(8'hF0, 8, q);
		desel();
		idle_wait();
		check(u_arr.mem[12'h0FE], 8'h10);
		cmd(OP_WREN);
		sel();
		xfer(OP_RDSR, 8, q);
		hold_n <= 1'b0;
		tick(10);
		check({7'h00, dq1_oe}, 8'h00);
		xfer(8'hFF, 4, q);
		hold_n <= 1'b1;
		tick(10);
		xfer(8'h00, 8, q);
		desel();
		check(q, 8'h02);
		cmd(OP_WRDI);
		hdr(OP_SSE, 24'h000000);
		desel();
		rdsr();
		check(st, 8'h00);
		check(u_arr.mem[12'h0FE], 8'h10);
		cmd(OP_WREN);
		hdr(OP_SSE, 24'h000000);
		desel();
		idle_wait();
		check(u_arr.mem[12'h0FE], 8'hFF);
		check(u_arr.mem[12'h000], 8'hFF);
		cpol <= 1'b1;
		sck  <= 1'b1;
		tick(20);
		cmd(OP_WREN);
		rdsr();
		check(st, 8'h02);
		hdr(OP_DP, 24'h000020);
		q = 8'h5A;
		for (int i = 3; i >= 0; i--)
			pulse(q[2*i], q[2*i+1], b);
		desel();
		idle_wait();
		check(u_arr.mem[12'h020], 8'h5A);
		cmd(OP_WREN);
		wp_n <= 1'b0;
		wr2(OP_WRSR, 8'h1C);
		idle_wait();
		check(st, 8'h00);
		wp_n <= 1'b1;
		cmd(OP_WREN);
		wr2(OP_WRSR, 8'h1C);
		idle_wait();
		check(st, 8'h1C);
		tally_and_finish();
	end
endmodule
